// ### core/etl_consts.vh
/*
 * Constants of the 8b/10b line codec: disparity values, sub-block
 * positions and patterns, special-character codes.
 * Assumes nothing; holds definitions only.
 */
`ifndef ETL_CONSTS_VH
`define ETL_CONSTS_VH

// ****************************************************************
// Running disparity
// ****************************************************************
`define ETL_RD_NEG      1'b0
`define ETL_RD_POS      1'b1
`define ETL_TX_RD_RST   1'b0

// ****************************************************************
// Character layout: c[9]=a .. c[4]=i, c[3]=f .. c[0]=j
// ****************************************************************
`define ETL_CHAR_BITS   4'ha
`define ETL_SB6_MSB     9
`define ETL_SB6_LSB     4
`define ETL_SB4_MSB     3
`define ETL_SB4_LSB     0
`define ETL_BAL6        3'h3
`define ETL_BAL4        3'h2
`define ETL_SB6_POSBAL  6'h07
`define ETL_SB6_NEGBAL  6'h38
`define ETL_SB4_POSBAL  4'h3
`define ETL_SB4_NEGBAL  4'hc

// ****************************************************************
// Special characters
// ****************************************************************
`define ETL_K28         5'h1c
`define ETL_K28_SB6     6'h0f
`define ETL_A7_SB4      4'h7

`endif

// ### core/etl_buf2.v
/*
 * Two-entry buffer with valid/ready on both sides.
 * Assumes one clock; the drain side may stall at will.
 */
`timescale 1ns/10ps
`default_nettype none

module etl_buf2 #(
	parameter W = 10
) (
	input  wire         sys_clk,
	input  wire         nrst,
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data
);

	reg [W-1:0] mem_q [0:1];
	reg         wp_q;
	reg         rp_q;
	reg   [1:0] cnt_q;
	wire        push;
	wire        pop;

	assign in_ready  = (cnt_q != 2'h2);
	assign out_valid = (cnt_q != 2'h0);
	assign out_data  = mem_q[rp_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always @(posedge sys_clk) begin
		if (push) begin
			mem_q[wp_q] <= in_data;
		end
	end

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wp_q  <= 1'b0;
			rp_q  <= 1'b0;
			cnt_q <= 2'h0;
		end else begin
			if (push) begin
				wp_q <= ~wp_q;
			end
			if (pop) begin
				rp_q <= ~rp_q;
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 2'h1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 2'h1;
			end
		end
	end

endmodule

`default_nettype wire

// ### core/etl_deser.v
/*
 * Receive deserializer: gathers bits, first bit (a) into the MSB, into
 * 10-bit characters. Assumes the line side marks the first bit of a
 * character with align; bits are synchronous to sys_clk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "etl_consts.vh"

module etl_deser (
	input  wire       sys_clk,
	input  wire       nrst,
	input  wire       bit_in,
	input  wire       bit_valid,
	input  wire       align,
	output reg  [9:0] char_q,
	output reg        char_valid_q
);

	reg [8:0] sh_q;
	reg [3:0] cnt_q;
	wire [3:0] cnt_d;

	assign cnt_d = align ? 4'h1 : cnt_q + 4'h1;

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sh_q         <= 9'h000;
			cnt_q        <= 4'h0;
			char_q       <= 10'h000;
			char_valid_q <= 1'b0;
		end else begin
			char_valid_q <= 1'b0;
			if (bit_valid) begin
				sh_q <= {sh_q[7:0], bit_in};
				if (cnt_d == `ETL_CHAR_BITS) begin
					char_q       <= {sh_q, bit_in};
					char_valid_q <= 1'b1;
					cnt_q        <= 4'h0;
				end else begin
					cnt_q <= cnt_d;
				end
			end
		end
	end

endmodule

`default_nettype wire

// ### core/etl_codec.v
/*
 * 8b/10b line codec: encoder with running disparity, serializer, and a
 * receive path with deserializer, decoder, validity check and disparity.
 * Assumes a single bit clock; the line side supplies character
 * alignment on receive.
 */
// Overview of operation
// RULE1: Each accepted byte becomes one 10-bit character, then shifted out serially.
// RULE2: Received bits are gathered into 10-bit characters and decoded to bytes.
// RULE3: All 256 byte values encode as data; some spare codes are specials.
// RULE4: Input is bits A..H plus data/special flag; output bits a,b,c,d,e,i,f,g,h,j.
// RULE5: Bit A is byte bit 0, through H as bit 7.
// RULE6: A byte without a type flag is encoded as data.
// RULE7: Special flag valid only for defined specials; others are invalid.
// RULE8: Serial order is a,b,c,d,e,i,f,g,h,j.
// RULE9: Ordered-set characters leave in the order presented, first one first.
// RULE10: Frame characters leave in presented order, delimiter to delimiter.
// RULE11: The code column used matches the present running disparity.
// RULE12: Transmitter starts negative after reset or leaving diagnostic mode.
// RULE13: Transmitter recomputes disparity from each character it sends.
// RULE14: Receiver starts at a chosen disparity after reset or diagnostic exit.
// RULE15: Receiver judges each character valid or not and updates disparity.
// RULE16: Disparity is worked per sub-block: abcdei then fghj.
// RULE17: Six-bit block starts at last disparity; four-bit block follows it.
// RULE18: More ones, or 000111 / 0011, ends a sub-block positive.
// RULE19: More zeros, or 111000 / 1100, ends a sub-block negative.
// RULE20: Other balanced sub-blocks keep their starting disparity.
// RULE21: 000111/0011 only from positive start, 111000/1100 only from negative.
// RULE22: Characters outside the current column flag a code error; disparity still updates.
// RULE23: One parallel character per clock on each side of the codec; here a character takes ten clocks, one per serial bit.
`timescale 1ns/10ps
`default_nettype none
`include "etl_consts.vh"

module etl_codec #(
	parameter RX_INIT_RD = 1'b0
) (
	input  wire       sys_clk,
	input  wire       nrst,
	input  wire       diag_mode,
	input  wire       tx_valid,
	output wire       tx_ready,
	input  wire [7:0] tx_data,
	input  wire       tx_special,
	input  wire       tx_type_given,
	output reg        tx_bad_special_q,
	output reg        tx_rd_q,
	output reg  [9:0] tx_char_q,
	output reg        tx_char_strobe_q,
	output wire       ser_bit,
	output wire       ser_bit_valid,
	output reg        ser_char_start_q,
	input  wire       rx_bit,
	input  wire       rx_bit_valid,
	input  wire       rx_align,
	output reg        rx_valid_q,
	output reg  [7:0] rx_data_q,
	output reg        rx_special_q,
	output reg        rx_code_err_q,
	output reg        rx_rd_q
);

	// ****************************************************************
	// Code functions
	// ****************************************************************
	function [2:0] pop6;
		input [5:0] s;
		begin
			pop6 = s[0] + s[1] + s[2] + s[3] + s[4] + s[5];
		end
	endfunction

	function [2:0] pop4;
		input [3:0] s;
		begin
			pop4 = s[0] + s[1] + s[2] + s[3];
		end
	endfunction

	// Disparity at the end of a six-bit sub-block
	function rd6;
		input       rd;
		input [5:0] s;
		begin
			if (pop6(s) > `ETL_BAL6 || s == `ETL_SB6_POSBAL) begin //RULE18
				rd6 = `ETL_RD_POS;
			end else if (pop6(s) < `ETL_BAL6 || s == `ETL_SB6_NEGBAL) begin //RULE19
				rd6 = `ETL_RD_NEG;
			end else begin
				rd6 = rd; //RULE20
			end
		end
	endfunction

	// Disparity at the end of a four-bit sub-block
	function rd4;
		input       rd;
		input [3:0] s;
		begin
			if (pop4(s) > `ETL_BAL4 || s == `ETL_SB4_POSBAL) begin //RULE18
				rd4 = `ETL_RD_POS;
			end else if (pop4(s) < `ETL_BAL4 || s == `ETL_SB4_NEGBAL) begin //RULE19
				rd4 = `ETL_RD_NEG;
			end else begin
				rd4 = rd; //RULE20
			end
		end
	endfunction

	// Whole-character disparity: six-bit block first, then four-bit
	function rd10;
		input       rd;
		input [9:0] c;
		begin
			rd10 = rd4(rd6(rd, c[`ETL_SB6_MSB:`ETL_SB6_LSB]), c[`ETL_SB4_MSB:`ETL_SB4_LSB]); //RULE16 RULE17
		end
	endfunction

	// Defined special characters: K28.y and K23/27/29/30.7
	function kvalid;
		input [4:0] x;
		input [2:0] y;
		begin
			kvalid = (x == `ETL_K28) ||
				(y == 3'h7 && (x == 5'h17 || x == 5'h1b || x == 5'h1d || x == 5'h1e)); //RULE7
		end
	endfunction

	// Six-bit sub-block abcdei for EDCBA = x at disparity rd
	function [5:0] enc6;
		input [4:0] x;
		input       k;
		input       rd;
		reg   [5:0] b;
		begin
			case (x)
				5'h00: b = 6'h27;
				5'h01: b = 6'h1d;
				5'h02: b = 6'h2d;
				5'h03: b = 6'h31;
				5'h04: b = 6'h35;
				5'h05: b = 6'h29;
				5'h06: b = 6'h19;
				5'h07: b = 6'h38;
				5'h08: b = 6'h39;
				5'h09: b = 6'h25;
				5'h0a: b = 6'h15;
				5'h0b: b = 6'h34;
				5'h0c: b = 6'h0d;
				5'h0d: b = 6'h2c;
				5'h0e: b = 6'h1c;
				5'h0f: b = 6'h17;
				5'h10: b = 6'h1b;
				5'h11: b = 6'h23;
				5'h12: b = 6'h13;
				5'h13: b = 6'h32;
				5'h14: b = 6'h0b;
				5'h15: b = 6'h2a;
				5'h16: b = 6'h1a;
				5'h17: b = 6'h3a;
				5'h18: b = 6'h33;
				5'h19: b = 6'h26;
				5'h1a: b = 6'h16;
				5'h1b: b = 6'h36;
				5'h1c: b = 6'h0e;
				5'h1d: b = 6'h2e;
				5'h1e: b = 6'h1e;
				default: b = 6'h2b;
			endcase
			if (k && x == `ETL_K28) begin
				b = `ETL_K28_SB6;
			end
			// Positive column: unbalanced blocks and 111000 flip
			if (rd && (pop6(b) != `ETL_BAL6 || b == `ETL_SB6_NEGBAL)) begin //RULE11 RULE21
				b = ~b;
			end
			enc6 = b;
		end
	endfunction

	// Four-bit sub-block fghj for HGF = y at mid-character disparity rd
	function [3:0] enc4;
		input [2:0] y;
		input [4:0] x;
		input       k;
		input       rd;
		reg   [3:0] b;
		reg         alt;
		begin
			// Alternate .7 avoids a run of five across the sub-block edge
			alt = k || (!rd && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
				(rd && (x == 5'h0b || x == 5'h0d || x == 5'h0e));
			case (y)
				3'h0: b = 4'hb;
				3'h1: b = 4'h9;
				3'h2: b = 4'h5;
				3'h3: b = 4'hc;
				3'h4: b = 4'hd;
				3'h5: b = 4'ha;
				3'h6: b = 4'h6;
				default: b = alt ? `ETL_A7_SB4 : 4'he;
			endcase
			if (rd && (pop4(b) != `ETL_BAL4 || b == `ETL_SB4_NEGBAL)) begin //RULE11 RULE21
				b = ~b;
			end
			// K28 in the positive column is the whole complement of its negative form
			if (k && x == `ETL_K28 && !rd &&
				pop4(b) == `ETL_BAL4 && b != `ETL_SB4_NEGBAL) begin //RULE11
				b = ~b;
			end
			enc4 = b;
		end
	endfunction

	// ****************************************************************
	// Transmit encoder
	// ****************************************************************
	wire [4:0] tx_x;
	wire [2:0] tx_y;
	wire       tx_kreq;
	wire       tx_k;
	wire [5:0] tx_s6;
	wire [3:0] tx_s4;
	wire [9:0] tx_code;
	wire       tx_acc;
	wire       buf_in_ready;
	wire       buf_out_valid;
	wire [9:0] buf_out_data;
	wire       ser_ready;
	reg        diag_q;
	wire       diag_exit;

	assign tx_x      = tx_data[4:0]; //RULE4 RULE5
	assign tx_y      = tx_data[7:5]; //RULE5
	assign tx_kreq   = tx_type_given & tx_special; //RULE6
	assign tx_k      = tx_kreq & kvalid(tx_x, tx_y); //RULE3 RULE7
	assign tx_s6     = enc6(tx_x, tx_k, tx_rd_q); //RULE11
	assign tx_s4     = enc4(tx_y, tx_x, tx_k, rd6(tx_rd_q, tx_s6)); //RULE17
	assign tx_code   = {tx_s6, tx_s4}; //RULE1 RULE4
	assign tx_ready  = buf_in_ready;
	assign tx_acc    = tx_valid & buf_in_ready;
	assign diag_exit = diag_q & ~diag_mode;

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			diag_q           <= 1'b0;
			tx_rd_q          <= `ETL_TX_RD_RST; //RULE12
			tx_bad_special_q <= 1'b0;
		end else begin
			diag_q           <= diag_mode;
			tx_bad_special_q <= tx_acc & tx_kreq & ~tx_k; //RULE7
			if (diag_exit) begin
				tx_rd_q <= `ETL_TX_RD_RST; //RULE12
			end else if (tx_acc) begin
				tx_rd_q <= rd10(tx_rd_q, tx_code); //RULE13
			end
		end
	end

	// Encoded characters queue here so a busy serializer drops nothing
	etl_buf2 #(
		.W (10)
	) u_tx_buf (
		.sys_clk   (sys_clk),
		.nrst      (nrst),
		.in_valid  (tx_valid),
		.in_ready  (buf_in_ready),
		.in_data   (tx_code),
		.out_valid (buf_out_valid),
		.out_ready (ser_ready),
		.out_data  (buf_out_data)
	); //RULE9 RULE10

	// ****************************************************************
	// Serializer
	// ****************************************************************
	reg  [9:0] sh_q;
	reg  [3:0] bit_cnt_q;
	wire       ser_load;

	assign ser_ready     = (bit_cnt_q <= 4'h1);
	assign ser_load      = buf_out_valid & ser_ready;
	assign ser_bit       = sh_q[9]; //RULE8
	assign ser_bit_valid = (bit_cnt_q != 4'h0);

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sh_q             <= 10'h000;
			bit_cnt_q        <= 4'h0;
			tx_char_q        <= 10'h000;
			tx_char_strobe_q <= 1'b0;
			ser_char_start_q <= 1'b0;
		end else begin
			tx_char_strobe_q <= ser_load; //RULE23
			ser_char_start_q <= ser_load;
			if (ser_load) begin
				sh_q      <= buf_out_data; //RULE1
				tx_char_q <= buf_out_data; //RULE23
				bit_cnt_q <= `ETL_CHAR_BITS;
			end else if (bit_cnt_q != 4'h0) begin
				sh_q      <= {sh_q[8:0], 1'b0}; //RULE8
				bit_cnt_q <= bit_cnt_q - 4'h1;
			end
		end
	end

	// ****************************************************************
	// Receive path
	// ****************************************************************
	wire [9:0] rx_char;
	wire       rx_char_valid;
	wire [5:0] rx_s6;
	wire [3:0] rx_s4;
	wire       rx_mid;
	reg        f6;
	reg        f4;
	reg  [4:0] dx;
	reg  [2:0] dy;
	reg        dk;
	integer    n;

	etl_deser u_rx_deser (
		.sys_clk      (sys_clk),
		.nrst         (nrst),
		.bit_in       (rx_bit),
		.bit_valid    (rx_bit_valid),
		.align        (rx_align),
		.char_q       (rx_char),
		.char_valid_q (rx_char_valid)
	); //RULE2

	assign rx_s6  = rx_char[`ETL_SB6_MSB:`ETL_SB6_LSB]; //RULE16
	assign rx_s4  = rx_char[`ETL_SB4_MSB:`ETL_SB4_LSB];
	assign rx_mid = rd6(rx_rd_q, rx_s6); //RULE17

	// Search only the column of the current disparity
	always @* begin
		f6 = 1'b0;
		f4 = 1'b0;
		dx = 5'h00;
		dy = 3'h0;
		dk = 1'b0;
		for (n = 0; n < 32; n = n + 1) begin
			if (!f6 && enc6(n[4:0], 1'b0, rx_rd_q) == rx_s6) begin //RULE11
				f6 = 1'b1;
				dx = n[4:0];
			end
		end
		if (!f6 && enc6(`ETL_K28, 1'b1, rx_rd_q) == rx_s6) begin
			f6 = 1'b1;
			dx = `ETL_K28;
			dk = 1'b1;
		end
		for (n = 0; n < 8; n = n + 1) begin
			if (!f4 && enc4(n[2:0], dx, dk, rx_mid) == rx_s4) begin
				f4 = 1'b1;
				dy = n[2:0];
			end
		end
		if (!f4 && !dk && kvalid(dx, 3'h7) && enc4(3'h7, dx, 1'b1, rx_mid) == rx_s4) begin //RULE7
			f4 = 1'b1;
			dy = 3'h7;
			dk = 1'b1;
		end
	end

	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rx_rd_q       <= RX_INIT_RD; //RULE14
			rx_valid_q    <= 1'b0;
			rx_data_q     <= 8'h00;
			rx_special_q  <= 1'b0;
			rx_code_err_q <= 1'b0;
		end else begin
			rx_valid_q <= rx_char_valid; //RULE23
			if (diag_exit) begin
				rx_rd_q <= RX_INIT_RD; //RULE14
			end else if (rx_char_valid) begin
				rx_rd_q <= rd10(rx_rd_q, rx_char); //RULE15 RULE22
			end
			if (rx_char_valid) begin
				rx_data_q     <= {dy, dx}; //RULE2 RULE5
				rx_special_q  <= dk;
				rx_code_err_q <= ~(f6 & f4); //RULE15 RULE22
			end
		end
	end

endmodule

`default_nettype wire

// ### test/etl_codec_sva.sv
/*
 Checker for etl_codec ports.
 Assumes one clock, bound to every etl_codec.
*/
`timescale 1ns/10ps
`default_nettype none
module etl_codec_sva #(
	parameter RX_INIT_RD = 1'b0
) (
	input wire logic       sys_clk,
	input wire logic       nrst,
	input wire logic       diag_mode,
	input wire logic       tx_valid,
	input wire logic       tx_ready,
	input wire logic       tx_special,
	input wire logic       tx_type_given,
	input wire logic       tx_bad_special_q,
	input wire logic       tx_rd_q,
	input wire logic [9:0] tx_char_q,
	input wire logic       tx_char_strobe_q,
	input wire logic       ser_bit,
	input wire logic       ser_bit_valid,
	input wire logic       ser_char_start_q,
	input wire logic       rx_valid_q,
	input wire logic       rx_rd_q
);
	// ***
	// Properties
	// ***
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	property p_strobe;
		tx_char_strobe_q |-> ser_char_start_q && ser_bit_valid;
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobe without start");
	property p_order;
		ser_char_start_q |-> ser_bit == tx_char_q[9] ##1 ser_bit == tx_char_q[8]
			##1 ser_bit == tx_char_q[7] ##1 ser_bit == tx_char_q[6] ##1 ser_bit == tx_char_q[5]
			##1 ser_bit == tx_char_q[4] ##1 ser_bit == tx_char_q[3] ##1 ser_bit == tx_char_q[2]
			##1 ser_bit == tx_char_q[1] ##1 ser_bit == tx_char_q[0];
	endproperty
	a_order: assert property (p_order) else $error("serial bit order");
	property p_len;
		ser_char_start_q |-> ser_bit_valid[*8] ##1 ser_bit_valid[*2];
	endproperty
	a_len: assert property (p_len) else $error("short character");
	property p_gap;
		ser_char_start_q |=> (!ser_char_start_q)[*8] ##1 !ser_char_start_q;
	endproperty
	a_gap: assert property (p_gap) else $error("starts too close");
	property p_diag;
		$fell(diag_mode) |-> ##[1:2] (tx_rd_q == 1'b0 && rx_rd_q == RX_INIT_RD);
	endproperty
	a_diag: assert property (p_diag) else $error("disparity not reset");
	property p_bad;
		tx_bad_special_q |-> $past(tx_valid && tx_ready && tx_type_given && tx_special);
	endproperty
	a_bad: assert property (p_bad) else $error("bad special pulse");
	property p_rxp;
		rx_valid_q |=> !rx_valid_q;
	endproperty
	a_rxp: assert property (p_rxp) else $error("rx valid too long");
	property p_txhold;
		$changed(tx_rd_q) |-> $past(tx_valid && tx_ready) || $past(diag_mode)
			|| $past(diag_mode, 2) || $past(diag_mode, 3);
	endproperty
	a_txhold: assert property (p_txhold) else $error("tx disparity moved");
endmodule
bind etl_codec etl_codec_sva #(.RX_INIT_RD(RX_INIT_RD)) u_etl_codec_sva (
	.sys_clk(sys_clk), .nrst(nrst), .diag_mode(diag_mode), .tx_valid(tx_valid),
	.tx_ready(tx_ready), .tx_special(tx_special), .tx_type_given(tx_type_given),
	.tx_bad_special_q(tx_bad_special_q), .tx_rd_q(tx_rd_q), .tx_char_q(tx_char_q),
	.tx_char_strobe_q(tx_char_strobe_q), .ser_bit(ser_bit), .ser_bit_valid(ser_bit_valid),
	.ser_char_start_q(ser_char_start_q), .rx_valid_q(rx_valid_q), .rx_rd_q(rx_rd_q)
);
`default_nettype wire

// ### test/etl_serdes_model.sv
/*
 Line loop below the codec: serial out back to serial in.
 Assumes the codec's own serial pins; flip_a corrupts bit a once.
*/
`timescale 1ns/10ps
`default_nettype none
module etl_serdes_model (
	input  wire logic sys_clk,
	input  wire logic nrst,
	input  wire logic ser_bit,
	input  wire logic ser_bit_valid,
	input  wire logic ser_char_start_q,
	input  wire logic flip_a,
	output var  logic rx_bit,
	output var  logic rx_bit_valid,
	output var  logic rx_align
);
	// ***
	// One-cycle loop, bit order kept
	// ***
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rx_bit <= 1'b0;
			rx_bit_valid <= 1'b0;
			rx_align <= 1'b0;
		end else begin
			// Idle line shows a changing level, never the last bit
			rx_bit <= ser_bit_valid ? ser_bit ^ (ser_char_start_q & flip_a) : ~rx_bit;
			rx_bit_valid <= ser_bit_valid;
			rx_align <= ser_char_start_q;
		end
	end
endmodule
`default_nettype wire

// ### test/eight_ten_bit_line_codec_tb.sv
/*
 Loopback bench for etl_codec with a queue model of both paths.
 Assumes etl_serdes_model closes the serial loop.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
	$display("Error %s exp %h got %h", nm, e, g); end end
module eight_ten_bit_line_codec_tb;
	logic       sys_clk = 0, nrst = 0, diag_mode = 0, tx_valid = 0, flip_a = 0;
	logic [7:0] tx_data = 0;
	logic       tx_special = 0, tx_type_given = 0, rx_bit, rx_bit_valid, rx_align;
	logic       tx_ready, tx_bad_special_q, tx_rd_q, tx_char_strobe_q, ser_bit;
	logic       ser_bit_valid, ser_char_start_q, rx_valid_q, rx_special_q;
	logic       rx_code_err_q, rx_rd_q, tx_m = 0, rx_m = 0, r6, e, saw_full = 0;
	logic [9:0] tx_char_q, ch;
	logic [7:0] rx_data_q;
	logic [8:0] bt;
	logic [9:0] tbl [6] = '{10'h274, 10'h38b, 10'h074, 10'h31b, 10'h22b, 10'h305};
	logic [7:0] seq [5] = '{8'h00, 8'h07, 8'h07, 8'h03, 8'h01};
	logic [9:0] cq [$];
	logic       eq [$];
	logic [8:0] bq [$];
	int num_errors = 0, n_compared = 0, idx = 0, nbad = 0, exp_bad = 0, i, n;
	integer seed = 32'h55f1, r;
	etl_codec u_etl_codec (.sys_clk(sys_clk), .nrst(nrst), .diag_mode(diag_mode),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_special(tx_special),
		.tx_type_given(tx_type_given), .tx_bad_special_q(tx_bad_special_q), .tx_rd_q(tx_rd_q),
		.tx_char_q(tx_char_q), .tx_char_strobe_q(tx_char_strobe_q), .ser_bit(ser_bit),
		.ser_bit_valid(ser_bit_valid), .ser_char_start_q(ser_char_start_q), .rx_bit(rx_bit),
		.rx_bit_valid(rx_bit_valid), .rx_align(rx_align), .rx_valid_q(rx_valid_q),
		.rx_data_q(rx_data_q), .rx_special_q(rx_special_q), .rx_code_err_q(rx_code_err_q),
		.rx_rd_q(rx_rd_q));
	etl_serdes_model u_etl_serdes_model (.sys_clk(sys_clk), .nrst(nrst), .ser_bit(ser_bit),
		.ser_bit_valid(ser_bit_valid), .ser_char_start_q(ser_char_start_q), .flip_a(flip_a),
		.rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid), .rx_align(rx_align));
	initial begin
		forever #10 sys_clk = ~sys_clk;
	end
	// ***
	// Disparity model per sub-block
	// ***
	function automatic logic sb(input logic rd, input int ones, input int half,
		input logic pb, input logic nb);
		return ones > half ? 1'b1 : ones < half ? 1'b0 : pb ? 1'b1 : nb ? 1'b0 : rd;
	endfunction
	function automatic logic rd_of(input logic rd, input logic [9:0] c);
		logic m;
		m = sb(rd, $countones(c[9:4]), 3, c[9:4] == 6'h07, c[9:4] == 6'h38);
		return sb(m, $countones(c[3:0]), 2, c[3:0] == 4'h3, c[3:0] == 4'hc);
	endfunction
	// Defined specials: K28.y and K23/27/29/30.7
	function automatic logic kdef(input logic [7:0] b);
		return b[4:0] == 5'h1c || (b[7:5] == 3'h7 &&
			(b[4:0] == 5'h17 || b[4:0] == 5'h1b || b[4:0] == 5'h1d || b[4:0] == 5'h1e));
	endfunction
	// ***
	// Monitors
	// ***
	always @(posedge sys_clk) begin
		if (tx_ready === 1'b0) saw_full = 1;
		if (tx_bad_special_q === 1'b1) nbad++;
		if (tx_char_strobe_q === 1'b1) begin
			ch = tx_char_q;
			n = $countones(ch);
			r6 = sb(tx_m, $countones(ch[9:4]), 3, ch[9:4] == 6'h07, ch[9:4] == 6'h38);
			`CHK("tx_column", 1'b1, (n == 5) || (n == (tx_m ? 4 : 6)))
			if (ch[9:4] == 6'h07 || ch[9:4] == 6'h38) `CHK("sb6_start", ch[9], ~tx_m)
			if (ch[3:0] == 4'h3 || ch[3:0] == 4'hc) `CHK("sb4_start", ch[3], ~r6)
			if (idx < 6) `CHK("tx_char", tbl[idx], ch)
			idx++;
			tx_m = rd_of(tx_m, ch);
			cq.push_back(flip_a ? ch ^ 10'h200 : ch);
			eq.push_back(flip_a);
			flip_a <= 1'b0;
		end
		if (rx_valid_q === 1'b1) begin
			`CHK("rx_pending", 1'b1, cq.size() > 0 && bq.size() > 0)
			if (cq.size() > 0 && bq.size() > 0) begin
				ch = cq.pop_front();
				e = eq.pop_front();
				bt = bq.pop_front();
				rx_m = rd_of(rx_m, ch);
				`CHK("rx_rd", rx_m, rx_rd_q)
				`CHK("rx_err", e, rx_code_err_q)
				if (!e) `CHK("rx_data", bt, {rx_special_q, rx_data_q})
			end
		end
	end
	// ***
	// Stimulus tasks
	// ***
	task automatic send(input logic [7:0] b, input logic k, input logic g);
		tx_valid <= 1'b1;
		tx_data <= b;
		tx_special <= k;
		tx_type_given <= g;
		for (i = 0; i < 100; i++) begin
			@(posedge sys_clk);
			if (tx_ready === 1'b1) break;
		end
		if (i == 100) begin
			`CHK("tx_ready", 1'b1, tx_ready)
			tally_and_finish();
		end
		bq.push_back({g & k & kdef(b), b});
		if (g & k & ~kdef(b)) exp_bad++;
	endtask
	task automatic drain;
		tx_valid <= 1'b0;
		for (i = 0; i < 3000 && bq.size() > 0; i++) @(posedge sys_clk);
		if (bq.size() > 0) begin
			`CHK("drain", 0, bq.size())
			tally_and_finish();
		end
		repeat (4) @(posedge sys_clk);
	endtask
	task automatic tally_and_finish;
		if (num_errors == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ***
	// Main sequence
	// ***
	initial begin
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		for (int j = 0; j < 5; j++) send(seq[j], 1'b0, 1'b1);
		send(8'hbc, 1'b1, 1'b1);
		send(8'h00, 1'b1, 1'b1);
		send(8'hbc, 1'b1, 1'b0);
		repeat (40) begin
			r = $random(seed);
			send(r[7:0], r[8], r[9]);
		end
		drain();
		if (tx_m == 1'b0) send(8'h03, 1'b0, 1'b1);
		drain();
		`CHK("tx_rd_pre", 1'b1, tx_rd_q)
		`CHK("rx_rd_pre", 1'b1, rx_rd_q)
		diag_mode <= 1'b1;
		repeat (3) @(posedge sys_clk);
		diag_mode <= 1'b0;
		repeat (4) @(posedge sys_clk);
		`CHK("tx_rd_diag", 1'b0, tx_rd_q)
		`CHK("rx_rd_diag", 1'b0, rx_rd_q)
		tx_m = 0;
		rx_m = 0;
		flip_a <= 1'b1;
		send(8'h00, 1'b0, 1'b1);
		drain();
		`CHK("bad_special", exp_bad, nbad)
		`CHK("buffer_full", 1'b1, saw_full)
		tally_and_finish();
	end
endmodule
`default_nettype wire
